/* File: core/pcg_pkg.sv */
`default_nettype none
package pcg_pkg;
  // ==========================================================================
  // register map (byte addresses on apb)
  localparam logic [7:0] PCG_OFF_CTRL = 8'h00;
  localparam logic [7:0] PCG_OFF_BW = 8'h04;
  localparam logic [7:0] PCG_OFF_PROG = 8'h08;

  // ==========================================================================
  // pll_ctrl field positions
  localparam int PCG_CTRL_IEN = 7;
  localparam int PCG_CTRL_FLAG = 6;
  localparam int PCG_CTRL_ON = 5;
  localparam int PCG_CTRL_BCS = 4;
  localparam logic [3:0] PCG_CTRL_LOW_ONES = 4'hf;

  // pll_bw_ctrl field positions
  localparam int PCG_BW_AUTO = 7;
  localparam int PCG_BW_LOCK = 6;
  localparam int PCG_BW_TRK = 5;
  localparam int PCG_BW_XLD = 4;

  // ==========================================================================
  // reset values
  localparam logic PCG_ON_RST = 1'b1;
  localparam logic [3:0] PCG_MUL_RST = 4'h6;
  localparam logic [3:0] PCG_VRS_RST = 4'h6;
  localparam logic [3:0] PCG_TEST_RST = 4'h0;

  // ==========================================================================
  // switch-over timing
  localparam logic [1:0] PCG_SW_EDGES = 2'h3;
  localparam logic [7:0] PCG_SW_TMO_CYC = 8'h40;

  typedef enum logic [0:0] {PCG_SW_IDLE, PCG_SW_WAIT} pcg_sw_state_t;
endpackage
`default_nettype wire

/* File: core/pcg_ctrl.sv */
// Operation
// - base clock is selected source divided by two, 50% duty
// - lock change flag with enable raises the lock interrupt line
// - lock interrupt enable unwritable and reads 0 in manual mode
// - lock change flag sets on lock toggle, reads 0 in manual mode
// - a read of pll_ctrl that returns the lock change flag set clears it
// - pll power-on cannot be cleared while source select is set
// - source select cannot be set while pll is off
// - switch-over waits three crystal and three vco edges, output held
// - reset and stop clear source select
// - four low bits of pll_ctrl read as ones
// - bandwidth self-control bit read/write, 1 automatic, reset clears
// - lock indicator read-only in automatic mode, 0 in manual
// - tracking bit is status in automatic, control in manual
// - manual tracking value kept across automatic mode
// - crystal loss bit works only while source select set
// - write 1 to crystal loss bit, activity clears it in time
// - multiplier code 0 acts as 1, reset loads 6
// - multiplier and range writes blocked while pll on
// - range 0 disables pll and clears/blocks source select
// - oscillator enable gates crystal clock and pll
// - pll power and source select never change in one write
// - stop holds crystal clock, base clock and interrupt low
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// three-stage level synchroniser; output changes once stages two and three agree
module pcg_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds s2 only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

// ============================================================================
// clock generator control
module pcg_ctrl (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system integration
  input wire logic osc_enable_in,
  input wire logic stop_in,
  // analog oscillator and pll
  input wire logic xtal_osc_in,
  input wire logic vco_clk,
  input wire logic lock_det_in,
  input wire logic trk_det_in,
  // clock and interrupt outputs
  output logic xtal_clk,
  output logic base_clk_out,
  output logic lock_irq,
  // pll steering outputs
  output logic pll_enable_out,
  output logic bw_auto_out,
  output logic trk_ctrl_out,
  output logic [3:0] fb_multiplier,
  output logic [3:0] vco_range
);
  // ==========================================================================
  // state
  logic lock_irq_en;
  logic lock_change_flag;
  logic pll_power_on;
  logic base_src_sel;
  logic bw_auto;
  logic trk_manual;
  logic xtal_loss_det;
  logic [3:0] test_bits;
  logic [3:0] mul;
  logic [3:0] vrs;
  logic xtal_lvl;
  logic vco_lvl;
  logic lock_lvl;
  logic trk_lvl;
  logic xtal_prev;
  logic vco_prev;
  logic lock_prev;
  pcg_pkg::pcg_sw_state_t sw_state;
  logic active_sel;
  logic [1:0] xcnt;
  logic [1:0] vcnt;
  logic [7:0] tmo;
  logic next_on;
  logic next_bcs;
  logic [7:0] rd_byte;

  // ==========================================================================
  // input synchronisers for the analog side
  pcg_sync u_sync_xtal (.clk(pclk), .rst_n(presetn), .d(xtal_osc_in), .q(xtal_lvl));
  pcg_sync u_sync_vco (.clk(pclk), .rst_n(presetn), .d(vco_clk), .q(vco_lvl));
  pcg_sync u_sync_lock (.clk(pclk), .rst_n(presetn), .d(lock_det_in), .q(lock_lvl));
  pcg_sync u_sync_trk (.clk(pclk), .rst_n(presetn), .d(trk_det_in), .q(trk_lvl));

  // previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_prev <= 1'b0;
      vco_prev <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      xtal_prev <= xtal_lvl;
      vco_prev <= vco_lvl;
      lock_prev <= lock_lvl;
    end
  end

  logic xtal_rise;
  logic vco_rise;
  logic lock_toggle;
  assign xtal_rise = xtal_lvl & ~xtal_prev;
  assign vco_rise = vco_lvl & ~vco_prev;
  assign lock_toggle = lock_lvl ^ lock_prev;

  // ==========================================================================
  // apb decode; zero wait states
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_bw;
  logic hit_prog;
  logic mapped;
  logic wr_ctrl;
  logic wr_bw;
  logic wr_prog;
  logic rd_ctrl;
  logic [7:0] wdat;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = (paddr == pcg_pkg::PCG_OFF_CTRL);
  assign hit_bw = (paddr == pcg_pkg::PCG_OFF_BW);
  assign hit_prog = (paddr == pcg_pkg::PCG_OFF_PROG);
  assign mapped = hit_ctrl | hit_bw | hit_prog;
  assign wr_ctrl = access & pwrite & hit_ctrl;
  assign wr_bw = access & pwrite & hit_bw;
  assign wr_prog = access & pwrite & hit_prog;
  assign rd_ctrl = access & ~pwrite & hit_ctrl;
  assign wdat = pwdata[7:0];
  assign pready = 1'b1;

  // read mux; gated fields read as zero in manual mode
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = {lock_irq_en & bw_auto, lock_change_flag & bw_auto, pll_power_on, base_src_sel,
                 pcg_pkg::PCG_CTRL_LOW_ONES};
    end else if (hit_bw) begin
      rd_byte = {bw_auto, lock_lvl & bw_auto, bw_auto ? trk_lvl : trk_manual,
                 xtal_loss_det & base_src_sel, test_bits};
    end else if (hit_prog) begin
      rd_byte = {mul, vrs};
    end
  end

  // read data and error captured in setup, held through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= setup & ~mapped;
    end
  end

  // ==========================================================================
  // power-on and source select interlock
  always_comb begin
    next_on = pll_power_on;
    next_bcs = base_src_sel;
    if (wr_ctrl) begin
      // a write that would change both is refused whole
      if (!((wdat[pcg_pkg::PCG_CTRL_ON] != pll_power_on) &&
            (wdat[pcg_pkg::PCG_CTRL_BCS] != base_src_sel))) begin
        if (wdat[pcg_pkg::PCG_CTRL_ON] || !base_src_sel) begin
          next_on = wdat[pcg_pkg::PCG_CTRL_ON];
        end
        if (!wdat[pcg_pkg::PCG_CTRL_BCS] || (pll_power_on && vrs != 4'h0)) begin
          next_bcs = wdat[pcg_pkg::PCG_CTRL_BCS];
        end
      end
    end
    if (stop_in || vrs == 4'h0) begin
      next_bcs = 1'b0;
    end
  end

  // pll_ctrl storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_power_on <= pcg_pkg::PCG_ON_RST;
      base_src_sel <= 1'b0;
      lock_irq_en <= 1'b0;
    end else begin
      pll_power_on <= next_on;
      base_src_sel <= next_bcs;
      if (wr_ctrl && bw_auto) begin
        lock_irq_en <= wdat[pcg_pkg::PCG_CTRL_IEN];
      end
    end
  end

  // lock change flag; a toggle beats a clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_change_flag <= 1'b0;
    end else if (!bw_auto) begin
      lock_change_flag <= 1'b0;
    end else if (lock_toggle) begin
      lock_change_flag <= 1'b1;
    end else if (rd_ctrl && prdata[pcg_pkg::PCG_CTRL_FLAG]) begin
      // only a flag that the reader actually saw is cleared
      lock_change_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // bandwidth control; manual tracking value survives automatic mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_auto <= 1'b0;
      trk_manual <= 1'b0;
      test_bits <= pcg_pkg::PCG_TEST_RST;
    end else if (wr_bw) begin
      bw_auto <= wdat[pcg_pkg::PCG_BW_AUTO];
      if (!bw_auto) begin
        trk_manual <= wdat[pcg_pkg::PCG_BW_TRK];
      end
      test_bits <= wdat[3:0];
    end
  end

  // crystal loss: write 1 arms, a rising crystal edge clears; idle unless vco drives out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_loss_det <= 1'b0;
    end else if (!base_src_sel) begin
      xtal_loss_det <= 1'b0;
    end else if (wr_bw && wdat[pcg_pkg::PCG_BW_XLD]) begin
      xtal_loss_det <= 1'b1;
    end else if (xtal_rise) begin
      xtal_loss_det <= 1'b0;
    end
  end

  // ==========================================================================
  // programming register, frozen while the pll runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul <= pcg_pkg::PCG_MUL_RST;
      vrs <= pcg_pkg::PCG_VRS_RST;
    end else if (wr_prog && !pll_power_on) begin
      mul <= wdat[7:4];
      vrs <= wdat[3:0];
    end
  end

  // ==========================================================================
  // switch-over control; timeout keeps a dead clock from hanging the switch
  logic sw_done;
  assign sw_done = ((xcnt == pcg_pkg::PCG_SW_EDGES) && (vcnt == pcg_pkg::PCG_SW_EDGES)) || (tmo == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= pcg_pkg::PCG_SW_IDLE;
      active_sel <= 1'b0;
      xcnt <= 2'h0;
      vcnt <= 2'h0;
      tmo <= pcg_pkg::PCG_SW_TMO_CYC;
    end else begin
      case (sw_state)
        pcg_pkg::PCG_SW_IDLE: begin
          xcnt <= 2'h0;
          vcnt <= 2'h0;
          tmo <= pcg_pkg::PCG_SW_TMO_CYC;
          if (base_src_sel != active_sel) begin
            sw_state <= pcg_pkg::PCG_SW_WAIT;
          end
        end
        pcg_pkg::PCG_SW_WAIT: begin
          if (xtal_rise && xcnt != pcg_pkg::PCG_SW_EDGES) begin
            xcnt <= xcnt + 2'h1;
          end
          if (vco_rise && vcnt != pcg_pkg::PCG_SW_EDGES) begin
            vcnt <= vcnt + 2'h1;
          end
          if (tmo != 8'h00) begin
            tmo <= tmo - 8'h01;
          end
          if (sw_done) begin
            active_sel <= base_src_sel;
            sw_state <= pcg_pkg::PCG_SW_IDLE;
          end
        end
        default: begin
          sw_state <= pcg_pkg::PCG_SW_IDLE;
        end
      endcase
    end
  end

  // base clock: one toggle per source rising edge gives half rate, 50% duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_clk_out <= 1'b0;
    end else if (stop_in) begin
      base_clk_out <= 1'b0;
    end else if (sw_state == pcg_pkg::PCG_SW_IDLE && base_src_sel == active_sel &&
                 (active_sel ? vco_rise : xtal_rise)) begin
      base_clk_out <= ~base_clk_out;
    end
  end

  // ==========================================================================
  // registered outputs to the system and the analog pll
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_clk <= 1'b0;
      lock_irq <= 1'b0;
      pll_enable_out <= 1'b0;
      bw_auto_out <= 1'b0;
      trk_ctrl_out <= 1'b0;
      fb_multiplier <= pcg_pkg::PCG_MUL_RST;
      vco_range <= pcg_pkg::PCG_VRS_RST;
    end else begin
      xtal_clk <= xtal_lvl & osc_enable_in & ~stop_in;
      lock_irq <= lock_change_flag & lock_irq_en & bw_auto & ~stop_in;
      pll_enable_out <= pll_power_on & osc_enable_in & (vrs != 4'h0) & ~stop_in;
      bw_auto_out <= bw_auto;
      trk_ctrl_out <= trk_manual;
      fb_multiplier <= (mul == 4'h0) ? 4'h1 : mul;
      vco_range <= vrs;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_irq_cause;
    lock_irq |-> $past(lock_change_flag) && $past(lock_irq_en) && $past(bw_auto) && !$past(stop_in);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("lock irq without flag and enable");

  property p_irq_follow;
    (lock_change_flag && lock_irq_en && bw_auto && !stop_in) |=> lock_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("lock irq missing");

  property p_ien_manual;
    (setup && !pwrite && hit_ctrl && !bw_auto) |=> !prdata[7] && !prdata[6];
  endproperty
  a_ien_manual: assert property (p_ien_manual) else $error("enable or flag visible in manual");

  property p_flag_set;
    (bw_auto && lock_toggle) |=> lock_change_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lock toggle lost");

  property p_flag_clr;
    (rd_ctrl && prdata[6] && !lock_toggle) |=> !lock_change_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("read did not clear flag");

  property p_on_hold;
    base_src_sel |=> pll_power_on;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("pll off while vco selected");

  property p_bcs_rise;
    $rose(base_src_sel) |-> $past(pll_power_on) && $past(vrs) != 4'h0 && $past(wr_ctrl);
  endproperty
  a_bcs_rise: assert property (p_bcs_rise) else $error("select set with pll off");

  property p_no_double;
    ($changed(pll_power_on)) |-> !$changed(base_src_sel);
  endproperty
  a_no_double: assert property (p_no_double) else $error("power and select changed together");

  property p_held;
    (sw_state == pcg_pkg::PCG_SW_WAIT) |=> $stable(base_clk_out);
  endproperty
  a_held: assert property (p_held) else $error("base clock moved during switch");

  property p_stop;
    stop_in |=> !base_src_sel && !base_clk_out && !xtal_clk && !lock_irq;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left outputs active");

  property p_low_ones;
    (setup && !pwrite && hit_ctrl) |=> prdata[3:0] == 4'hf;
  endproperty
  a_low_ones: assert property (p_low_ones) else $error("low ctrl bits not ones");

  property p_prog_lock;
    pll_power_on |=> $stable(mul) && $stable(vrs);
  endproperty
  a_prog_lock: assert property (p_prog_lock) else $error("programming changed with pll on");

  property p_range_zero;
    (vrs == 4'h0) |=> !base_src_sel && !pll_enable_out;
  endproperty
  a_range_zero: assert property (p_range_zero) else $error("zero range left pll usable");

  property p_mult;
    fb_multiplier != 4'h0;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier output zero");

  property p_xld_off;
    !base_src_sel |=> !xtal_loss_det;
  endproperty
  a_xld_off: assert property (p_xld_off) else $error("crystal loss active without vco select");

  c_bcs_set: cover property ($rose(base_src_sel));
  c_switch_done: cover property ((sw_state == pcg_pkg::PCG_SW_WAIT) ##1 (sw_state == pcg_pkg::PCG_SW_IDLE));
  c_irq: cover property ($rose(lock_irq));
  c_flag_read: cover property (rd_ctrl && prdata[6]);
endmodule
`default_nettype wire

/* File: test/pcg_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_ctrl_bench;
  // ==========================================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic osc_enable_in, stop_in, lock_det_in, trk_det_in;
  // given a start value here so the source process is their only driver
  logic xtal_osc_in = 1'b0;
  logic vco_clk = 1'b0;
  logic xtal_clk, base_clk_out, lock_irq, pll_enable_out, bw_auto_out, trk_ctrl_out;
  logic [3:0] fb_multiplier, vco_range;
  logic [1:0] xc = 2'h0;
  logic [1:0] vc = 2'h0;
  logic xtal_run, re;
  logic [7:0] rv;
  int error_cnt, check_count, h, l, hits;
  localparam logic [7:0] CTRL = pcg_pkg::PCG_OFF_CTRL;
  localparam logic [7:0] BW = pcg_pkg::PCG_OFF_BW;
  localparam logic [7:0] PROG = pcg_pkg::PCG_OFF_PROG;

  pcg_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_enable_in(osc_enable_in), .stop_in(stop_in), .xtal_osc_in(xtal_osc_in),
    .vco_clk(vco_clk), .lock_det_in(lock_det_in), .trk_det_in(trk_det_in),
    .xtal_clk(xtal_clk), .base_clk_out(base_clk_out), .lock_irq(lock_irq),
    .pll_enable_out(pll_enable_out), .bw_auto_out(bw_auto_out), .trk_ctrl_out(trk_ctrl_out),
    .fb_multiplier(fb_multiplier), .vco_range(vco_range)
  );

  // ==========================================================================
  // clock and slow sources; crystal period 8 cycles, vco period 6 cycles
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // sources made from pclk so half periods are exact and measurable
  always @(posedge pclk) begin
    xc <= xc + 2'h1;
    vc <= (vc == 2'h2) ? 2'h0 : vc + 2'h1;
    if (xc == 2'h3 && xtal_run) begin
      xtal_osc_in <= ~xtal_osc_in;
    end
    if (vc == 2'h2) begin
      vco_clk <= ~vco_clk;
    end
  end

  // ==========================================================================
  // reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("ERROR wait expected done seen timeout");
    end_of_test();
  endtask

  // ==========================================================================
  // apb master; a leading edge keeps release and next setup apart
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      hang();
    end
    rv = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // registered outputs get two edges to follow a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    xfer(1'b0, a, 8'h00);
    check(what, {24'h0, rv}, {24'h0, exp});
  endtask

  // ==========================================================================
  // base clock measurement; first run is partial and discarded
  task automatic run_len(input logic v, output int c);
    int n;
    n = 0;
    c = 0;
    while (base_clk_out !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    while (base_clk_out === v && c < 200) begin
      @(posedge pclk);
      c++;
    end
    if (n >= 200 || c >= 200) begin
      hang();
    end
  endtask

  task automatic period(input int exp);
    run_len(1'b1, h);
    run_len(1'b0, l);
    run_len(1'b1, h);
    check("base low", l, exp);
    check("base high", h, exp);
  endtask

  // counts cycles in which a gated output shows high
  task automatic quiet(input int cyc, input logic all);
    hits = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (xtal_clk === 1'b1 || pll_enable_out === 1'b1) hits++;
      if (all && (base_clk_out === 1'b1 || lock_irq === 1'b1)) hits++;
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    osc_enable_in = 1'b1; stop_in = 1'b0;
    lock_det_in = 1'b0; trk_det_in = 1'b0; xtal_run = 1'b1;
    error_cnt = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped word
    rd(CTRL, 8'h2f, "ctrl reset");
    rd(BW, 8'h00, "bw reset");
    rd(PROG, 8'h66, "prog reset");
    check("mult", fb_multiplier, 4'h6);
    check("enable", pll_enable_out, 1'b1);
    xfer(1'b0, 8'h0c, 8'h00);
    check("unmapped err", re, 1'b1);
    check("unmapped data", rv, 8'h00);
    $display("test reset done");
    // oscillator enable gates crystal and pll
    osc_enable_in <= 1'b0;
    repeat (3) @(posedge pclk);
    quiet(20, 1'b0);
    check("osc off highs", hits, 0);
    osc_enable_in <= 1'b1;
    // crystal clock must come back once the enable returns
    h = 0;
    while (xtal_clk !== 1'b1 && h < 20) begin
      @(posedge pclk);
      h++;
    end
    check("xtal on", xtal_clk, 1'b1);
    $display("test oscillator enable done");
    // write protection between power, select and programming
    wr(PROG, 8'h05);
    rd(PROG, 8'h66, "prog while on");
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h0f, "power off");
    wr(PROG, 8'h05);
    check("mult zero", fb_multiplier, 4'h1);
    rd(PROG, 8'h05, "prog off");
    wr(PROG, 8'hf5);
    check("mult f", fb_multiplier, 4'hf);
    check("range", vco_range, 4'h5);
    wr(CTRL, 8'h10);
    rd(CTRL, 8'h0f, "select while off");
    wr(CTRL, 8'h30);
    rd(CTRL, 8'h0f, "on and select");
    wr(BW, 8'h00);
    wr(CTRL, 8'h20);
    rd(CTRL, 8'h2f, "power on");
    period(8);
    wr(CTRL, 8'h30);
    rd(CTRL, 8'h3f, "select");
    wr(CTRL, 8'h10);
    rd(CTRL, 8'h3f, "off while selected");
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h3f, "off and deselect");
    repeat (80) @(posedge pclk);
    period(6);
    $display("test protection done");
    // crystal loss: stall the crystal, then let it run for N*4 cycles
    xtal_run <= 1'b0;
    repeat (10) @(posedge pclk);
    wr(BW, 8'h10);
    rd(BW, 8'h10, "loss set");
    xtal_run <= 1'b1;
    repeat (15 * 4) @(posedge pclk);
    rd(BW, 8'h00, "loss cleared");
    $display("test crystal loss done");
    // manual then automatic bandwidth, lock flag and interrupt
    wr(CTRL, 8'hb0);
    rd(CTRL, 8'h3f, "enable in manual");
    wr(BW, 8'h20);
    check("trk out", trk_ctrl_out, 1'b1);
    lock_det_in <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(BW, 8'h20, "manual bw");
    rd(CTRL, 8'h3f, "manual flag");
    wr(BW, 8'ha0);
    check("auto out", bw_auto_out, 1'b1);
    rd(BW, 8'hc0, "auto bw");
    rd(CTRL, 8'h3f, "enable ignored");
    wr(CTRL, 8'hb0);
    rd(CTRL, 8'hbf, "enable in auto");
    check("irq idle", lock_irq, 1'b0);
    lock_det_in <= 1'b0;
    h = 0;
    while (lock_irq !== 1'b1 && h < 20) begin
      @(posedge pclk);
      h++;
    end
    check("irq raised", lock_irq, 1'b1);
    rd(CTRL, 8'hff, "flag set");
    repeat (3) @(posedge pclk);
    check("irq dropped", lock_irq, 1'b0);
    rd(CTRL, 8'hbf, "flag cleared");
    trk_det_in <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(BW, 8'ha0, "auto status");
    wr(BW, 8'h80);
    wr(BW, 8'h00);
    check("trk restored", trk_ctrl_out, 1'b1);
    rd(BW, 8'h20, "manual again");
    rd(CTRL, 8'h3f, "enable hidden");
    $display("test bandwidth done");
    // stop holds outputs low and deselects the vco
    stop_in <= 1'b1;
    repeat (3) @(posedge pclk);
    quiet(20, 1'b1);
    check("stop highs", hits, 0);
    stop_in <= 1'b0;
    rd(CTRL, 8'h2f, "after stop");
    period(8);
    $display("test stop done");
    // range zero disables the pll and blocks selection
    wr(CTRL, 8'h00);
    wr(PROG, 8'hf0);
    rd(PROG, 8'hf0, "range zero");
    wr(CTRL, 8'h20);
    check("range0 enable", pll_enable_out, 1'b0);
    wr(CTRL, 8'h30);
    rd(CTRL, 8'h2f, "range0 select");
    wr(BW, 8'h10);
    rd(BW, 8'h00, "loss unselected");
    $display("test range zero done");
    end_of_test();
  end

  // ==========================================================================
  // overall guard against a hang outside the bounded waits
  initial begin
    repeat (50000) @(posedge pclk);
    hang();
  end
endmodule
`default_nettype wire
